//--- verilog/dcs_params.sv
`include "dcs_regs.svh"

// Functional notes
// - remote frequency source accepts 0-5, 8, 9; other codes refused.
// - remote run source accepts 0, 1, 2, 5; other codes refused.
// - remote selections act only with assigned input or external keypad fitted.
// - direction 0 both, 1 no reverse, 2 no forward; blocked runs refused.
// - format bits 3:0 hold decimal places, 0 to 3.
// - format bits 15:4 hold unit code, Hz upward to CFM.
// - maximum word 0 disables scaling; otherwise raw count 1-65535.
// - raw maximum is read through the selected decimal places.
module dcs_params
    import dcs_pkg::*;
(
    // clock, reset, enable
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // parameter access from the serial protocol engine
    input  wire dcs_word_t  reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire dcs_word_t  reg_wdata,
    output logic            reg_ack,
    output dcs_word_t       reg_rdata,
    output logic            reg_err,
    output logic [7:0]      reg_exc,
    // source selection context
    input  wire logic       hand_off_auto_function,
    input  wire logic       ext_keypad_present,
    input  wire logic [3:0] local_freq_src,
    input  wire logic [3:0] local_run_src,
    output logic [3:0]      freq_source,
    output logic [3:0]      run_source,
    output logic            remote_active,
    output logic            stop_coast,
    // keypad frequency memory update
    input  wire logic       keypad_freq_load,
    input  wire dcs_word_t  keypad_freq_in,
    // run requests
    input  wire logic       run_fwd_req,
    input  wire logic       run_rev_req,
    output logic            run_fwd_grant,
    output logic            run_rev_grant,
    output logic            run_refused,
    // user display scaling
    input  wire dcs_word_t  scale_ratio,
    output logic            scale_enable,
    output logic [3:0]      scale_decimals,
    output logic [11:0]     scale_unit,
    output dcs_word_t       scale_int,
    output dcs_word_t       scale_frac
);
    dcs_word_t   freq_src_reg;
    dcs_word_t   run_src_reg;
    dcs_word_t   stop_reg;
    dcs_word_t   dir_reg;
    dcs_word_t   kpd_mem_reg;
    dcs_word_t   fmt_reg;
    dcs_word_t   max_reg;
    dcs_word_t   scaled_reg;
    dcs_word_t   scaled_next;
    dcs_word_t   int_next;
    dcs_word_t   frac_next;
    dcs_word_t   rdata_next;
    logic        enable_next;
    logic        wr_take;
    logic        rd_take;
    logic        wr_ok;
    logic [7:0]  exc_next;
    logic        remote_next;
    dcs_dir_t    dir_mode;

    // address decode for reads; writes are checked per word below
    function automatic logic is_mapped(input dcs_word_t a);
        is_mapped = (a >= `DCS_ADDR_FREQ_SRC) && (a <= `DCS_ADDR_SCALE_VAL);
    endfunction

    // a write wins over a simultaneous read
    assign wr_take = ce && reg_wr;
    assign rd_take = ce && reg_rd && !reg_wr;
    assign dir_mode = dcs_dir_t'(dir_reg[1:0]);

    // value check per word; refused writes leave the word untouched
    always_comb begin
        wr_ok    = 1'b0;
        exc_next = `DCS_EXC_VALUE;
        case (reg_addr)
            `DCS_ADDR_FREQ_SRC:
                wr_ok = (reg_wdata <= `DCS_FSRC_PULSE_DIR) ||
                        (reg_wdata == `DCS_FSRC_CARD) ||
                        (reg_wdata == `DCS_FSRC_PID);
            `DCS_ADDR_RUN_SRC:
                wr_ok = (reg_wdata <= `DCS_RSRC_RS485) ||
                        (reg_wdata == `DCS_RSRC_CARD);
            `DCS_ADDR_STOP:
                wr_ok = (reg_wdata <= `DCS_STOP_MAX);
            `DCS_ADDR_DIR:
                wr_ok = (reg_wdata <= `DCS_DIR_MAX);
            `DCS_ADDR_SCALE_FMT:
                wr_ok = (reg_wdata[`DCS_DP_MSB:`DCS_DP_LSB] <= `DCS_DP_THREE) &&
                        (reg_wdata[`DCS_UNIT_MSB:`DCS_UNIT_LSB] <= `DCS_UNIT_MAX);
            `DCS_ADDR_SCALE_MAX:
                wr_ok = 1'b1;
            default: begin
                // read-only words and unmapped addresses alike
                wr_ok    = 1'b0;
                exc_next = `DCS_EXC_ADDR;
            end
        endcase
        if (wr_ok) begin
            exc_next = `DCS_EXC_NONE;
        end
    end

    // read mux; unmapped addresses read as zero with an exception
    always_comb begin
        case (reg_addr)
            `DCS_ADDR_FREQ_SRC:  rdata_next = freq_src_reg;
            `DCS_ADDR_RUN_SRC:   rdata_next = run_src_reg;
            `DCS_ADDR_STOP:      rdata_next = stop_reg;
            `DCS_ADDR_DIR:       rdata_next = dir_reg;
            `DCS_ADDR_KPD_MEM:   rdata_next = kpd_mem_reg;
            `DCS_ADDR_SCALE_FMT: rdata_next = fmt_reg;
            `DCS_ADDR_SCALE_MAX: rdata_next = max_reg;
            `DCS_ADDR_SCALE_VAL: rdata_next = scaled_reg;
            default:             rdata_next = `DCS_RST_ZERO;
        endcase
    end

    // writable configuration words
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            freq_src_reg <= `DCS_RST_ZERO;
            run_src_reg  <= `DCS_RST_ZERO;
            stop_reg     <= `DCS_RST_ZERO;
            dir_reg      <= `DCS_RST_ZERO;
            fmt_reg      <= `DCS_RST_ZERO;
            max_reg      <= `DCS_RST_ZERO;
        end else if (wr_take && wr_ok) begin
            case (reg_addr)
                `DCS_ADDR_FREQ_SRC:  freq_src_reg <= reg_wdata;
                `DCS_ADDR_RUN_SRC:   run_src_reg  <= reg_wdata;
                `DCS_ADDR_STOP:      stop_reg     <= reg_wdata;
                `DCS_ADDR_DIR:       dir_reg      <= reg_wdata;
                `DCS_ADDR_SCALE_FMT: fmt_reg      <= reg_wdata;
                `DCS_ADDR_SCALE_MAX: max_reg      <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // keypad memory follows only the device's own load strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            kpd_mem_reg <= `DCS_RST_KPD_MEM;
        end else if (ce && keypad_freq_load) begin
            kpd_mem_reg <= keypad_freq_in;
        end
    end

    // answer one cycle after the request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_ack   <= 1'b0;
            reg_rdata <= `DCS_RST_ZERO;
            reg_err   <= 1'b0;
            reg_exc   <= `DCS_EXC_NONE;
        end else if (ce) begin
            reg_ack <= wr_take || rd_take;
            if (wr_take) begin
                reg_rdata <= `DCS_RST_ZERO;
                reg_err   <= !wr_ok;
                reg_exc   <= exc_next;
            end else if (rd_take) begin
                reg_rdata <= rdata_next;
                reg_err   <= !is_mapped(reg_addr);
                reg_exc   <= is_mapped(reg_addr) ? `DCS_EXC_NONE : `DCS_EXC_ADDR;
            end else begin
                reg_err <= 1'b0;
                reg_exc <= `DCS_EXC_NONE;
            end
        end
    end

    // remote words steer the drive only when the selector hardware exists
    assign remote_next = hand_off_auto_function || ext_keypad_present;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            freq_source   <= 4'h0;
            run_source    <= 4'h0;
            remote_active <= 1'b0;
            stop_coast    <= 1'b0;
        end else if (ce) begin
            remote_active <= remote_next;
            freq_source   <= remote_next ? freq_src_reg[`DCS_SRC_MSB:0] : local_freq_src;
            run_source    <= remote_next ? run_src_reg[`DCS_SRC_MSB:0] : local_run_src;
            stop_coast    <= stop_reg[`DCS_STOP_BIT];
        end
    end

    // run gating; a refused request holds run_refused high while it stands
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            run_fwd_grant <= 1'b0;
            run_rev_grant <= 1'b0;
            run_refused   <= 1'b0;
        end else if (ce) begin
            run_fwd_grant <= run_fwd_req && (dir_mode != DCS_DIR_NO_FWD);
            run_rev_grant <= run_rev_req && (dir_mode != DCS_DIR_NO_REV);
            run_refused   <= (run_fwd_req && (dir_mode == DCS_DIR_NO_FWD)) ||
                             (run_rev_req && (dir_mode == DCS_DIR_NO_REV));
        end
    end

    // division is combinational; registering here keeps it off the outputs
    dcs_scale u_scale (
        .fmt_word  (fmt_reg),
        .max_word  (max_reg),
        .ratio     (scale_ratio),
        .scaled    (scaled_next),
        .int_part  (int_next),
        .frac_part (frac_next),
        .enable    (enable_next)
    );

    // scaled value and display parts; disabled scaling shows zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scaled_reg     <= `DCS_RST_ZERO;
            scale_enable   <= 1'b0;
            scale_decimals <= `DCS_DP_NONE;
            scale_unit     <= 12'h000;
            scale_int      <= `DCS_RST_ZERO;
            scale_frac     <= `DCS_RST_ZERO;
        end else if (ce) begin
            scale_enable   <= enable_next;
            scaled_reg     <= enable_next ? scaled_next : `DCS_RST_ZERO;
            scale_decimals <= fmt_reg[`DCS_DP_MSB:`DCS_DP_LSB];
            scale_unit     <= fmt_reg[`DCS_UNIT_MSB:`DCS_UNIT_LSB];
            scale_int      <= enable_next ? int_next : `DCS_RST_ZERO;
            scale_frac     <= enable_next ? frac_next : `DCS_RST_ZERO;
        end
    end

    // checks next to the logic above
    property p_freq_reject;
        @(posedge clock) disable iff (!rst_n)
        (wr_take && reg_addr == `DCS_ADDR_FREQ_SRC &&
         (reg_wdata == 16'h0006 || reg_wdata == 16'h0007 || reg_wdata > `DCS_FSRC_PID))
        |=> reg_err && reg_exc == `DCS_EXC_VALUE && $stable(freq_src_reg);
    endproperty
    a_freq_reject: assert property (p_freq_reject)
        else $error("bad frequency source code accepted");

    property p_freq_accept;
        @(posedge clock) disable iff (!rst_n)
        (wr_take && reg_addr == `DCS_ADDR_FREQ_SRC && reg_wdata == `DCS_FSRC_PID)
        |=> !reg_err && reg_ack && freq_src_reg == `DCS_FSRC_PID;
    endproperty
    a_freq_accept: assert property (p_freq_accept)
        else $error("PID frequency source not stored");

    property p_run_reject;
        @(posedge clock) disable iff (!rst_n)
        (wr_take && reg_addr == `DCS_ADDR_RUN_SRC &&
         (reg_wdata == 16'h0003 || reg_wdata == 16'h0004 || reg_wdata > `DCS_RSRC_CARD))
        |=> reg_err && $stable(run_src_reg);
    endproperty
    a_run_reject: assert property (p_run_reject)
        else $error("bad run source code accepted");

    property p_remote_gate;
        @(posedge clock) disable iff (!rst_n)
        (ce && !hand_off_auto_function && !ext_keypad_present)
        |=> !remote_active && freq_source == $past(local_freq_src) &&
            run_source == $past(local_run_src);
    endproperty
    a_remote_gate: assert property (p_remote_gate)
        else $error("remote source used without selector");

    property p_rev_block;
        @(posedge clock) disable iff (!rst_n)
        (ce && run_rev_req && dir_reg == 16'h0001)
        |=> !run_rev_grant && run_refused;
    endproperty
    a_rev_block: assert property (p_rev_block)
        else $error("reverse run granted while blocked");

    property p_fwd_block;
        @(posedge clock) disable iff (!rst_n)
        (ce && run_fwd_req && dir_reg == 16'h0002)
        |=> !run_fwd_grant && run_refused;
    endproperty
    a_fwd_block: assert property (p_fwd_block)
        else $error("forward run granted while blocked");

    property p_fmt_reject;
        @(posedge clock) disable iff (!rst_n)
        (wr_take && reg_addr == `DCS_ADDR_SCALE_FMT &&
         (reg_wdata[3:0] > 4'h3 || reg_wdata[15:4] > 12'h024))
        |=> reg_err ##1 scale_decimals <= 4'h3 && scale_unit <= 12'h024;
    endproperty
    a_fmt_reject: assert property (p_fmt_reject)
        else $error("bad scaling format accepted");

    property p_scale_off;
        @(posedge clock) disable iff (!rst_n)
        (ce && max_reg == 16'h0000)
        |=> !scale_enable && scaled_reg == 16'h0000 && scale_int == 16'h0000;
    endproperty
    a_scale_off: assert property (p_scale_off)
        else $error("scaling active with zero maximum");

    property p_three_dp;
        @(posedge clock) disable iff (!rst_n)
        (ce && max_reg != 16'h0000 && fmt_reg[3:0] == 4'h3)
        |=> scale_frac < 16'h03E8 &&
            32'(scale_int) * 32'h3E8 + 32'(scale_frac) == 32'($past(scaled_next));
    endproperty
    a_three_dp: assert property (p_three_dp)
        else $error("three decimal split wrong");

    property p_ro_write;
        @(posedge clock) disable iff (!rst_n)
        (wr_take && !keypad_freq_load &&
         (reg_addr == `DCS_ADDR_KPD_MEM || reg_addr == `DCS_ADDR_SCALE_VAL))
        |=> reg_err && reg_exc == `DCS_EXC_ADDR && $stable(kpd_mem_reg);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("write to read-only word took effect");
endmodule

//--- verilog/dcs_regs.svh
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH

// parameter word addresses
`define DCS_ADDR_FREQ_SRC   16'h0014
`define DCS_ADDR_RUN_SRC    16'h0015
`define DCS_ADDR_STOP       16'h0016
`define DCS_ADDR_DIR        16'h0017
`define DCS_ADDR_KPD_MEM    16'h0018
`define DCS_ADDR_SCALE_FMT  16'h0019
`define DCS_ADDR_SCALE_MAX  16'h001A
`define DCS_ADDR_SCALE_VAL  16'h001B

// reset values
`define DCS_RST_ZERO        16'h0000
`define DCS_RST_KPD_MEM     16'h003C

// scaling format fields
`define DCS_DP_MSB          3
`define DCS_DP_LSB          0
`define DCS_UNIT_MSB        15
`define DCS_UNIT_LSB        4
`define DCS_DP_NONE         4'h0
`define DCS_DP_ONE          4'h1
`define DCS_DP_TWO          4'h2
`define DCS_DP_THREE        4'h3
`define DCS_UNIT_MAX        12'h024

// source and option codes
`define DCS_FSRC_PULSE_DIR  16'h0005
`define DCS_FSRC_CARD       16'h0008
`define DCS_FSRC_PID        16'h0009
`define DCS_RSRC_RS485      16'h0002
`define DCS_RSRC_CARD       16'h0005
`define DCS_STOP_MAX        16'h0001
`define DCS_STOP_BIT        0
`define DCS_DIR_MAX         16'h0002
`define DCS_SRC_MSB         3

// decimal scaling divisors and ratio shift
`define DCS_DIV_TEN         32'h0000000A
`define DCS_DIV_HUNDRED     32'h00000064
`define DCS_DIV_THOUSAND    32'h000003E8
`define DCS_DIV_ONE         32'h00000001
`define DCS_RATIO_SHIFT     16

// exception codes in the answer
`define DCS_EXC_NONE        8'h00
`define DCS_EXC_ADDR        8'h02
`define DCS_EXC_VALUE       8'h03

`endif

//--- verilog/dcs_pkg.sv
`include "dcs_regs.svh"

package dcs_pkg;
    typedef logic [15:0] dcs_word_t;
    // direction permission as stored in the low bits
    typedef enum logic [1:0] {
        DCS_DIR_BOTH,
        DCS_DIR_NO_REV,
        DCS_DIR_NO_FWD
    } dcs_dir_t;
endpackage

//--- verilog/dcs_scale.sv
`include "dcs_regs.svh"

// scales a full-scale fraction to the user maximum and splits it by decimals
module dcs_scale
    import dcs_pkg::*;
(
    // configuration
    input  wire dcs_word_t  fmt_word,
    input  wire dcs_word_t  max_word,
    // live fraction of full scale, 0 .. 65535/65536
    input  wire dcs_word_t  ratio,
    // results
    output dcs_word_t       scaled,
    output dcs_word_t       int_part,
    output dcs_word_t       frac_part,
    output logic            enable
);
    logic [31:0] product;
    logic [31:0] value32;
    logic [31:0] divisor;

    // multiply then drop the fraction; truncation keeps scaled below max
    always_comb begin
        product = {16'h0000, ratio} * {16'h0000, max_word};
        value32 = product >> `DCS_RATIO_SHIFT;
        scaled  = value32[15:0];
        enable  = (max_word != `DCS_RST_ZERO);
    end

    // decimals only change how the raw count is read, never the count itself
    always_comb begin
        case (fmt_word[`DCS_DP_MSB:`DCS_DP_LSB])
            `DCS_DP_ONE:   divisor = `DCS_DIV_TEN;
            `DCS_DP_TWO:   divisor = `DCS_DIV_HUNDRED;
            `DCS_DP_THREE: divisor = `DCS_DIV_THOUSAND;
            default:       divisor = `DCS_DIV_ONE;
        endcase
        int_part  = 16'(value32 / divisor);
        frac_part = 16'(value32 % divisor);
    end
endmodule

//--- tb/dcs_host.sv
// bus master model driving the parameter access port
module dcs_host
    import dcs_pkg::*;
(
    // clock
    input  wire logic       clock,
    // request side
    output logic            reg_wr,
    output logic            reg_rd,
    output dcs_word_t       reg_addr,
    output dcs_word_t       reg_wdata,
    // answer side
    input  wire logic       reg_ack,
    input  wire dcs_word_t  reg_rdata,
    input  wire logic       reg_err,
    input  wire logic [7:0] reg_exc
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end

    // one-cycle strobe, then wait a bounded time for the answer
    task automatic access(input logic wr, input dcs_word_t addr, input dcs_word_t data,
                          output dcs_word_t rdata, output logic err,
                          output logic [7:0] exc, output logic ok);
        ok = 1'b0;
        rdata = 16'hXXXX;
        err = 1'bx;
        exc = 8'hXX;
        @(posedge clock);
        #1;
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = addr;
        reg_wdata = data;
        // the answer stands only for the cycle after the taking edge
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clock);
            #1;
            if (i == 0) begin
                // released lines must not keep the old value, so flip them
                reg_wr = 1'b0;
                reg_rd = 1'b0;
                reg_addr = ~addr;
                reg_wdata = ~data;
            end
            if (reg_ack === 1'b1) begin
                ok = 1'b1;
                rdata = reg_rdata;
                err = reg_err;
                exc = reg_exc;
            end
        end
    endtask
endmodule

//--- tb/dcs_params_bench.sv
`include "dcs_regs.svh"

module dcs_params_bench
    import dcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // stimulus and observed signals
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic       ce, hand_off_auto_function, ext_keypad_present, keypad_freq_load;
    logic       run_fwd_req, run_rev_req, reg_wr, reg_rd, reg_ack, reg_err;
    logic       remote_active, stop_coast, run_fwd_grant, run_rev_grant, run_refused;
    logic       scale_enable;
    logic [3:0] local_freq_src, local_run_src, freq_source, run_source, scale_decimals;
    logic [7:0] reg_exc;
    logic [11:0] scale_unit;
    dcs_word_t  reg_addr, reg_wdata, reg_rdata, keypad_freq_in, scale_ratio;
    dcs_word_t  scale_int, scale_frac;
    int         n_fail = 0;
    int         num_checks = 0;
    int         p;

    // 50 MHz clock
    always #10 clock = ~clock;

    dcs_params u_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
        .reg_rdata(reg_rdata), .reg_err(reg_err), .reg_exc(reg_exc),
        .hand_off_auto_function(hand_off_auto_function),
        .ext_keypad_present(ext_keypad_present),
        .local_freq_src(local_freq_src), .local_run_src(local_run_src),
        .freq_source(freq_source), .run_source(run_source), .remote_active(remote_active),
        .stop_coast(stop_coast), .keypad_freq_load(keypad_freq_load),
        .keypad_freq_in(keypad_freq_in), .run_fwd_req(run_fwd_req),
        .run_rev_req(run_rev_req), .run_fwd_grant(run_fwd_grant),
        .run_rev_grant(run_rev_grant), .run_refused(run_refused), .scale_ratio(scale_ratio),
        .scale_enable(scale_enable), .scale_decimals(scale_decimals),
        .scale_unit(scale_unit), .scale_int(scale_int), .scale_frac(scale_frac));

    dcs_host u_host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
        .reg_err(reg_err), .reg_exc(reg_exc));

    // counts and verdict, the single exit point
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // wide enough for the longest packed group compared below
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // one access plus a check of the refusal code
    task automatic xfer(input logic wr, input dcs_word_t a, input dcs_word_t d,
                        input logic [7:0] e, output dcs_word_t v);
        logic       err, ok;
        logic [7:0] exc;
        u_host.access(wr, a, d, v, err, exc, ok);
        if (!ok) begin
            n_fail++;
            finish_test();
        end
        chk(err, e != 8'h00);
        chk(exc, e);
    endtask

    task automatic w(input dcs_word_t a, input dcs_word_t d, input logic [7:0] e);
        dcs_word_t v;
        xfer(1'b1, a, d, e, v);
    endtask

    task automatic r(input dcs_word_t a, input dcs_word_t d, input logic [7:0] e);
        dcs_word_t v;
        xfer(1'b0, a, 16'h0000, e, v);
        chk(v, d);
    endtask

    // main sequence; accepted-code masks are bit-per-code
    initial begin
        ce = 1'b1;
        {hand_off_auto_function, ext_keypad_present, keypad_freq_load} = 3'h0;
        {run_fwd_req, run_rev_req} = 2'h0;
        local_freq_src = 4'h7;
        local_run_src = 4'h6;
        keypad_freq_in = 16'h0000;
        scale_ratio = 16'h8000;
        tick(3);
        chk(reg_ack, 1'b0);
        rst_n = 1'b1;
        for (int a = 16'h14; a <= 16'h1B; a++) begin
            r(16'(a), (a == 16'h18) ? `DCS_RST_KPD_MEM : `DCS_RST_ZERO, 8'h00);
        end
        r(16'h0013, 16'h0000, 8'h02);
        r(16'h001C, 16'h0000, 8'h02);
        for (int i = 0; i < 16; i++) begin
            w(`DCS_ADDR_FREQ_SRC, 16'(i), (16'h033F >> i) & 1 ? 8'h00 : 8'h03);
        end
        r(`DCS_ADDR_FREQ_SRC, 16'h0009, 8'h00);
        for (int i = 0; i < 8; i++) begin
            w(`DCS_ADDR_RUN_SRC, 16'(i), (16'h0027 >> i) & 1 ? 8'h00 : 8'h03);
        end
        r(`DCS_ADDR_RUN_SRC, 16'h0005, 8'h00);
        // remote selections only count with an assigned input or keypad
        tick(3);
        chk({remote_active, freq_source, run_source}, 9'h076);
        // a low enable must freeze the source outputs even when the keypad appears
        ce = 1'b0;
        ext_keypad_present = 1'b1;
        tick(3);
        chk({remote_active, freq_source, run_source}, 9'h076);
        ce = 1'b1;
        tick(3);
        chk({remote_active, freq_source, run_source}, 9'h195);
        ext_keypad_present = 1'b0;
        hand_off_auto_function = 1'b1;
        tick(3);
        chk({remote_active, freq_source, run_source}, 9'h195);
        hand_off_auto_function = 1'b0;
        tick(3);
        chk({remote_active, freq_source, run_source}, 9'h076);
        w(`DCS_ADDR_STOP, 16'h0001, 8'h00);
        w(`DCS_ADDR_STOP, 16'h0002, 8'h03);
        tick(2);
        chk(stop_coast, 1'b1);
        // both directions requested under each permission
        for (int d = 0; d < 3; d++) begin
            w(`DCS_ADDR_DIR, 16'(d), 8'h00);
            {run_fwd_req, run_rev_req} = 2'h3;
            tick(3);
            chk({run_fwd_grant, run_rev_grant, run_refused}, {d != 2, d != 1, d != 0});
            {run_fwd_req, run_rev_req} = 2'h0;
        end
        w(`DCS_ADDR_DIR, 16'h0003, 8'h03);
        w(`DCS_ADDR_KPD_MEM, 16'h1111, 8'h02);
        r(`DCS_ADDR_KPD_MEM, 16'h003C, 8'h00);
        keypad_freq_in = 16'h1234;
        keypad_freq_load = 1'b1;
        tick(1);
        keypad_freq_load = 1'b0;
        r(`DCS_ADDR_KPD_MEM, 16'h1234, 8'h00);
        w(`DCS_ADDR_SCALE_VAL, 16'h0001, 8'h02);
        w(`DCS_ADDR_SCALE_FMT, 16'h0240, 8'h00);
        w(`DCS_ADDR_SCALE_FMT, 16'h0250, 8'h03);
        w(`DCS_ADDR_SCALE_FMT, 16'h0244, 8'h03);
        tick(3);
        chk({scale_unit, scale_enable, scale_int, scale_frac}, {12'h024, 33'h0});
        w(`DCS_ADDR_SCALE_MAX, 16'hFFFF, 8'h00);
        tick(3);
        chk(scale_enable, 1'b1);
        r(`DCS_ADDR_SCALE_VAL, 16'h7FFF, 8'h00);
        // half of full scale split by each decimal count
        p = 1;
        for (int dp = 0; dp < 4; dp++) begin
            w(`DCS_ADDR_SCALE_FMT, 16'h0010 | 16'(dp), 8'h00);
            tick(3);
            chk({scale_unit, scale_decimals}, {12'h001, 4'(dp)});
            chk(scale_int, 32'(32767 / p));
            chk(scale_frac, 32'(32767 % p));
            p = p * 10;
        end
        // second reset in mid-run restores defaults
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        r(`DCS_ADDR_FREQ_SRC, 16'h0000, 8'h00);
        r(`DCS_ADDR_KPD_MEM, 16'h003C, 8'h00);
        finish_test();
    end
endmodule
